/* rtl/ocr_pkg.sv */
// package: register map, fields and reset values
package ocr_pkg;
   // register offsets on the serial bus
   localparam logic [7:0] OCR_ADDR_TARGET = 8'h08; // bus_target_address
   localparam logic [7:0] OCR_ADDR_REV = 8'h09; // image_revision
   localparam logic [7:0] OCR_ADDR_CTL = 8'h0a; // device_control
   localparam logic [7:0] OCR_ADDR_MARG_HI = 8'h10; // margin_offset_high, offset bits 1:0
   localparam logic [7:0] OCR_ADDR_MARG_LO = 8'h11; // margin_offset_low, offset bits 9:2
   // device_control field positions
   localparam int OCR_CTL_PDN = 6; // pll_power_down
   localparam int OCR_CTL_SE_SEL = 5; // single-ended output select
   localparam int OCR_CTL_RSVD_HI = 4; // reserved rw field top
   localparam int OCR_CTL_RSVD_LO = 2; // reserved rw field bottom
   localparam int OCR_CTL_TRIG = 1; // calibration_trigger
   localparam int OCR_CTL_AUTO = 0; // auto_start
   // pre-image reset values
   localparam logic [6:0] OCR_RST_TARGET = 7'h59; // bus_target_address
   localparam logic [7:0] OCR_RST_REV = 8'h00; // image_revision
   localparam logic [7:0] OCR_RST_CTL = 8'h01; // device_control, auto_start set
   localparam logic [1:0] OCR_RST_MARG_HI = 2'h0; // offset bits 1:0
   localparam logic [7:0] OCR_RST_MARG_LO = 8'h80; // offset bits 9:2
   // control sequencer states
   typedef enum logic [2:0] {
      OCR_CONFIG,
      OCR_HALT,
      OCR_CALIB,
      OCR_LOCKWAIT,
      OCR_RUN,
      OCR_PWRDN
   } ocr_state_type;
   // serial target states
   typedef enum logic [2:0] {
      OCR_I_IDLE,
      OCR_I_ADDR,
      OCR_I_ACK_A,
      OCR_I_REG,
      OCR_I_WDATA,
      OCR_I_ACK_W,
      OCR_I_RDATA,
      OCR_I_ACK_R
   } ocr_i2c_state_type;
endpackage : ocr_pkg

/* rtl/ocr_i2c_target.sv */
// i2c target: address match, pointer, byte writes and reads
module ocr_i2c_target (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // reset
   input wire logic scl_in, // bus clock pin
   input wire logic sda_in, // bus data pin level
   output logic sda_out, // always low
   output logic sda_oe_out, // pulls data low
   input wire logic [6:0] target_addr_in, // own bus address
   output logic wr_out, // write strobe
   output logic [7:0] wr_addr_out, // write offset
   output logic [7:0] wr_data_out, // write data
   output logic [7:0] rd_addr_out, // read register offset
   input wire logic [7:0] rd_data_in // read data
);
   import ocr_pkg::*;

   logic [2:0] scl_sync_q; // scl synchroniser chain
   logic [2:0] sda_sync_q; // sda synchroniser chain
   logic scl_f_q; // accepted scl level
   logic sda_f_q; // accepted sda level
   logic scl_p_q; // previous accepted scl
   logic sda_p_q; // previous accepted sda
   ocr_i2c_state_type st_q; // transfer state
   logic [3:0] cnt_q; // bits of current byte
   logic [7:0] sh_q; // shift register
   logic [7:0] ptr_q; // register pointer
   logic rw_q; // read transfer
   logic scl_rise, scl_fall, start_seen, stop_seen;

   // three-flop synchronisers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_in};
         sda_sync_q <= {sda_sync_q[1:0], sda_in};
         if (scl_sync_q[1] == scl_sync_q[2]) begin
            scl_f_q <= scl_sync_q[2];
         end
         if (sda_sync_q[1] == sda_sync_q[2]) begin
            sda_f_q <= sda_sync_q[2];
         end
         scl_p_q <= scl_f_q;
         sda_p_q <= sda_f_q;
      end
   end

   // bus events
   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign start_seen = scl_f_q & scl_p_q & ~sda_f_q & sda_p_q;
   assign stop_seen = scl_f_q & scl_p_q & sda_f_q & ~sda_p_q;
   assign rd_addr_out = ptr_q;

   // transfer sequencer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= OCR_I_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
         wr_out <= 1'b0;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
      end else begin
         wr_out <= 1'b0;
         if (start_seen) begin
            st_q <= OCR_I_ADDR;
            cnt_q <= 4'h0;
            sda_oe_out <= 1'b0;
         end else if (stop_seen) begin
            st_q <= OCR_I_IDLE;
            sda_oe_out <= 1'b0;
         end else if (scl_rise) begin
            case (st_q)
               OCR_I_ADDR, OCR_I_REG, OCR_I_WDATA: begin
                  sh_q <= {sh_q[6:0], sda_f_q};
                  cnt_q <= cnt_q + 4'h1;
               end
               OCR_I_RDATA: begin
                  cnt_q <= cnt_q + 4'h1;
               end
               OCR_I_ACK_R: begin
                  // host nack ends the read
                  if (sda_f_q) begin
                     st_q <= OCR_I_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (st_q)
               OCR_I_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     // answer only to own address
                     if (sh_q[7:1] == target_addr_in) begin
                        st_q <= OCR_I_ACK_A;
                        rw_q <= sh_q[0];
                        sda_oe_out <= 1'b1;
                     end else begin
                        st_q <= OCR_I_IDLE;
                     end
                  end
               end
               OCR_I_ACK_A: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     st_q <= OCR_I_RDATA;
                     sh_q <= rd_data_in;
                     sda_oe_out <= ~rd_data_in[7];
                  end else begin
                     st_q <= OCR_I_REG;
                     sda_oe_out <= 1'b0;
                  end
               end
               OCR_I_REG: begin
                  if (cnt_q == 4'h8) begin
                     ptr_q <= sh_q;
                     st_q <= OCR_I_ACK_W;
                     sda_oe_out <= 1'b1;
                  end
               end
               OCR_I_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     wr_out <= 1'b1;
                     wr_addr_out <= ptr_q;
                     ptr_q <= ptr_q + 8'h01;
                     wr_data_out <= sh_q;
                     st_q <= OCR_I_ACK_W;
                     sda_oe_out <= 1'b1;
                  end
               end
               OCR_I_ACK_W: begin
                  cnt_q <= 4'h0;
                  st_q <= OCR_I_WDATA;
                  sda_oe_out <= 1'b0;
               end
               OCR_I_RDATA: begin
                  if (cnt_q == 4'h8) begin
                     st_q <= OCR_I_ACK_R;
                     ptr_q <= ptr_q + 8'h01;
                     sda_oe_out <= 1'b0;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_out <= ~sh_q[6];
                  end
               end
               OCR_I_ACK_R: begin
                  cnt_q <= 4'h0;
                  st_q <= OCR_I_RDATA;
                  sh_q <= rd_data_in;
                  sda_oe_out <= ~rd_data_in[7];
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule // ocr_i2c_target

/* rtl/ocr_regs.sv */
// oscillator control bank: image-loaded registers, pll sequencer, serial target
// Notes on behaviour
// - read-only 7-bit bus address, own address only
// - bus address loaded from memory image
// - revision fetched after reset and commit
// - power-down clear after reset: enable, calibrate if auto-start set
// - power-down set: pll off, calibration reset
// - power-down cleared: re-enable, recalibrate automatically
// - trigger rising edge in halt or run starts calibration, resets 0
// - trigger self-clears when calibration finishes
// - auto-start set: lock then enable outputs
// - power-on, pin, software bit reset device
// - auto-start clear: halt until trigger rises
// - 10-bit margin offset over two registers
module ocr_regs (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // power-on reset
   input wire logic reset_pin_n_in, // reset pin
   input wire logic software_reset_bit_in, // software reset pulse
   input wire logic scl_in, // serial clock pin
   input wire logic sda_in, // serial data pin level
   output logic sda_out, // serial data drive value
   output logic sda_oe_out, // serial data drive enable
   input wire logic [6:0] nvm_target_address_in, // image: bus address
   input wire logic [7:0] nvm_image_revision_in, // image: revision id
   input wire logic [7:0] nvm_device_control_in, // image: control byte
   input wire logic [9:0] nvm_margin_offset_in, // image: margin offset
   input wire logic nvm_commit_in, // image commit done pulse
   input wire logic cal_done_in, // calibration done
   input wire logic pll_lock_in, // pll locked level
   output logic pll_enable_out, // pll powered
   output logic cal_reset_out, // calibration reset
   output logic cal_start_out, // calibration start
   output logic lock_enable_out, // lock attempt enabled
   output logic output_enable_out, // clock outputs enabled
   output logic [9:0] crystal_margin_offset_out // margin offset
);
   import ocr_pkg::*;

   logic [2:0] pin_sync_q; // reset pin synchroniser
   logic pin_n_q; // accepted pin level
   logic dev_rst_q; // internal device reset pulse
   logic [6:0] target_q; // bus_target_address
   logic [7:0] rev_q; // image_revision
   logic pdn_q; // pll_power_down
   logic se_sel_q; // single-ended select
   logic [2:0] rsvd_q; // reserved rw bits
   logic trig_q; // calibration_trigger
   logic auto_q; // auto_start
   logic [1:0] marg_hi_q; // offset bits 1:0
   logic [7:0] marg_lo_q; // offset bits 9:2
   ocr_state_type st_q; // sequencer state
   ocr_state_type st_d; // next sequencer state
   logic wr; // register write strobe
   logic [7:0] wr_addr; // write offset
   logic [7:0] wr_data; // write data
   logic [7:0] rd_addr; // read offset
   logic [7:0] rd_data; // read data
   logic ctl_wr; // write to device_control
   logic trig_rise; // trigger written 0 to 1
   logic config_now; // image load cycle

   // serial target
   ocr_i2c_target u_i2c (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .target_addr_in(target_q),
      .wr_out(wr),
      .wr_addr_out(wr_addr),
      .wr_data_out(wr_data),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data)
   );

   // reset pin synchroniser
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_sync_q <= 3'h7;
         pin_n_q <= 1'b1;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], reset_pin_n_in};
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_n_q <= pin_sync_q[2];
         end
      end
   end

   // device reset from pin or software bit
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dev_rst_q <= 1'b0;
      end else begin
         dev_rst_q <= ~pin_n_q | software_reset_bit_in;
      end
   end

   assign config_now = (st_q == OCR_CONFIG);
   assign ctl_wr = wr && (wr_addr == OCR_ADDR_CTL);
   assign trig_rise = ctl_wr && wr_data[OCR_CTL_TRIG] && !trig_q;

   // image-loaded read-only registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         target_q <= OCR_RST_TARGET;
         rev_q <= OCR_RST_REV;
      end else begin
         if (config_now) begin
            target_q <= nvm_target_address_in;
         end
         if (config_now || nvm_commit_in) begin
            rev_q <= nvm_image_revision_in;
         end
      end
   end

   // device_control, image-loaded except the trigger
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pdn_q <= OCR_RST_CTL[OCR_CTL_PDN];
         se_sel_q <= OCR_RST_CTL[OCR_CTL_SE_SEL];
         rsvd_q <= OCR_RST_CTL[OCR_CTL_RSVD_HI:OCR_CTL_RSVD_LO];
         auto_q <= OCR_RST_CTL[OCR_CTL_AUTO];
      end else if (config_now) begin
         pdn_q <= nvm_device_control_in[OCR_CTL_PDN];
         se_sel_q <= nvm_device_control_in[OCR_CTL_SE_SEL];
         rsvd_q <= nvm_device_control_in[OCR_CTL_RSVD_HI:OCR_CTL_RSVD_LO];
         auto_q <= nvm_device_control_in[OCR_CTL_AUTO];
      end else if (ctl_wr) begin
         pdn_q <= wr_data[OCR_CTL_PDN];
         se_sel_q <= wr_data[OCR_CTL_SE_SEL];
         rsvd_q <= wr_data[OCR_CTL_RSVD_HI:OCR_CTL_RSVD_LO];
         auto_q <= wr_data[OCR_CTL_AUTO];
      end
   end

   // calibration trigger, write beats self-clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_q <= OCR_RST_CTL[OCR_CTL_TRIG];
      end else if (config_now) begin
         trig_q <= OCR_RST_CTL[OCR_CTL_TRIG];
      end else if (ctl_wr) begin
         trig_q <= wr_data[OCR_CTL_TRIG];
      end else if (st_q == OCR_CALIB && cal_done_in) begin
         trig_q <= 1'b0;
      end
   end

   // margin offset halves
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         marg_hi_q <= OCR_RST_MARG_HI;
         marg_lo_q <= OCR_RST_MARG_LO;
      end else if (config_now) begin
         marg_hi_q <= nvm_margin_offset_in[1:0];
         marg_lo_q <= nvm_margin_offset_in[9:2];
      end else if (wr && wr_addr == OCR_ADDR_MARG_HI) begin
         marg_hi_q <= wr_data[1:0];
      end else if (wr && wr_addr == OCR_ADDR_MARG_LO) begin
         marg_lo_q <= wr_data;
      end
   end

   // read multiplexer, unused and unmapped bits read zero, reserved rw bits read back
   always_comb begin
      rd_data = 8'h00;
      case (rd_addr)
         OCR_ADDR_TARGET: rd_data = {target_q, 1'b0};
         OCR_ADDR_REV: rd_data = rev_q;
         OCR_ADDR_CTL: rd_data = {1'b0, pdn_q, se_sel_q, rsvd_q, trig_q, auto_q};
         OCR_ADDR_MARG_HI: rd_data = {6'h00, marg_hi_q};
         OCR_ADDR_MARG_LO: rd_data = marg_lo_q;
         default: rd_data = 8'h00;
      endcase
   end

   // sequencer next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         OCR_CONFIG: begin
            if (nvm_device_control_in[OCR_CTL_PDN]) begin
               st_d = OCR_PWRDN;
            end else if (nvm_device_control_in[OCR_CTL_AUTO]) begin
               st_d = OCR_CALIB;
            end else begin
               st_d = OCR_HALT;
            end
         end
         OCR_HALT: begin
            if (trig_rise) begin
               st_d = OCR_CALIB;
            end
         end
         OCR_CALIB: begin
            if (cal_done_in) begin
               st_d = OCR_LOCKWAIT;
            end
         end
         OCR_LOCKWAIT: begin
            if (pll_lock_in) begin
               st_d = OCR_RUN;
            end
         end
         OCR_RUN: begin
            if (trig_rise) begin
               st_d = OCR_CALIB;
            end
         end
         OCR_PWRDN: begin
            if (!pdn_q) begin
               st_d = OCR_CALIB;
            end
         end
         default: st_d = OCR_CONFIG;
      endcase
      // power-down overrides any running state
      if (st_q != OCR_CONFIG && pdn_q) begin
         st_d = OCR_PWRDN;
      end
   end

   // sequencer state, device reset restarts config
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= OCR_CONFIG;
      end else if (dev_rst_q) begin
         st_q <= OCR_CONFIG;
      end else begin
         st_q <= st_d;
      end
   end

   // registered pll controls from the next state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pll_enable_out <= 1'b0;
         cal_reset_out <= 1'b1;
         cal_start_out <= 1'b0;
         lock_enable_out <= 1'b0;
         output_enable_out <= 1'b0;
      end else begin
         pll_enable_out <= !dev_rst_q && st_d != OCR_PWRDN && st_d != OCR_CONFIG;
         cal_reset_out <= dev_rst_q || st_d == OCR_PWRDN || st_d == OCR_CONFIG;
         cal_start_out <= !dev_rst_q && st_d == OCR_CALIB && st_q != OCR_CALIB;
         lock_enable_out <= !dev_rst_q && (st_d == OCR_LOCKWAIT || st_d == OCR_RUN);
         output_enable_out <= !dev_rst_q && st_d == OCR_RUN;
      end
   end

   // margin offset to the crystal trim
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         crystal_margin_offset_out <= {OCR_RST_MARG_LO, OCR_RST_MARG_HI};
      end else begin
         crystal_margin_offset_out <= {marg_lo_q, marg_hi_q};
      end
   end
endmodule // ocr_regs

/* tb/ocr_regs_assertions.sv */
// checker: port-level timing of the control bank
module ocr_regs_checker (
   input wire logic clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic reset_pin_n_in, // pin reset
   input wire logic software_reset_bit_in, // sw reset
   input wire logic scl_in, // scl
   input wire logic sda_out, // sda value
   input wire logic sda_oe_out, // sda drive
   input wire logic cal_done_in, // cal done
   input wire logic pll_lock_in, // locked
   input wire logic pll_enable_out, // pll on
   input wire logic cal_reset_out, // cal reset
   input wire logic cal_start_out, // cal start
   input wire logic lock_enable_out, // lock on
   input wire logic output_enable_out // outputs on
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // device parked in its configuration phase
   sequence s_held;
      cal_reset_out && !pll_enable_out && !output_enable_out;
   endsequence
   // start strobe lasting exactly one cycle
   sequence s_pulse;
      cal_start_out ##1 !cal_start_out;
   endsequence
   property p_start_pulse; cal_start_out |-> s_pulse; endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start not one cycle");
   property p_start_live; cal_start_out |-> pll_enable_out && !cal_reset_out; endproperty
   a_start_live: assert property (p_start_live)
      else $error("start with pll off");
   property p_out_live; output_enable_out |-> pll_enable_out && !cal_reset_out; endproperty
   a_out_live: assert property (p_out_live)
      else $error("outputs with pll off");
   property p_pdn_quiet;
      !pll_enable_out |-> !lock_enable_out && !output_enable_out && !cal_start_out;
   endproperty
   a_pdn_quiet: assert property (p_pdn_quiet)
      else $error("activity in power-down");
   property p_out_after_lock; $rose(output_enable_out) |-> $past(pll_lock_in); endproperty
   a_out_after_lock: assert property (p_out_after_lock)
      else $error("outputs before lock");
   property p_lock_after_cal; $rose(lock_enable_out) |-> $past(cal_done_in); endproperty
   a_lock_after_cal: assert property (p_lock_after_cal)
      else $error("lock before cal end");
   property p_sda_low; sda_oe_out |-> !sda_out; endproperty
   a_sda_low: assert property (p_sda_low)
      else $error("data line driven high");
   property p_sda_frame; $changed(sda_oe_out) |-> !scl_in; endproperty
   a_sda_frame: assert property (p_sda_frame)
      else $error("data drive moved in scl high");
   property p_pin_reset; (!reset_pin_n_in) [*8] |-> s_held; endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("pin reset not held");
   property p_sw_reset; software_reset_bit_in |=> ##[0:3] s_held; endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("software reset not taken");
endmodule // ocr_regs_checker

bind ocr_regs ocr_regs_checker u_chk (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .reset_pin_n_in(reset_pin_n_in),
   .software_reset_bit_in(software_reset_bit_in),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe_out(sda_oe_out),
   .cal_done_in(cal_done_in),
   .pll_lock_in(pll_lock_in),
   .pll_enable_out(pll_enable_out),
   .cal_reset_out(cal_reset_out),
   .cal_start_out(cal_start_out),
   .lock_enable_out(lock_enable_out),
   .output_enable_out(output_enable_out)
);

/* tb/ocr_host_model.sv */
// host model: bus host driving the oscillator bank
module ocr_host_model (
   input wire logic clk_in, // system clock
   input wire logic sda_oe_in, // device pulls data low
   output logic scl_out, // bus clock
   output logic sda_drv_out, // host data, 1 releases
   output logic [7:0] ev_byte_out, // read byte or address ack flag
   output logic ev_valid_out // one-cycle event strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 12; // clocks per half bus period
   logic line; // wired data level, pulled up when released
   assign line = sda_drv_out & ~sda_oe_in;
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
      ev_byte_out = 8'h00;
      ev_valid_out = 1'b0;
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
   endtask
   // one-cycle report to the bench
   task automatic report(logic [7:0] b);
      ev_byte_out <= b;
      ev_valid_out <= 1'b1;
      tick(1);
      ev_valid_out <= 1'b0;
   endtask
   // one bit: data set while clock low, sampled at end of high phase
   task automatic bit_io(logic b, output logic s);
      sda_drv_out <= b;
      tick(HALF);
      scl_out <= 1'b1;
      tick(HALF);
      s = line;
      scl_out <= 1'b0;
   endtask
   // eight bits msb first, ninth slot carries k
   task automatic byte_io(logic [7:0] b, logic k, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
         r[i] = s;
      end
      bit_io(k, s);
      ack = ~s;
   endtask
   task automatic start();
      sda_drv_out <= 1'b1;
      tick(HALF);
      scl_out <= 1'b1;
      tick(HALF);
      sda_drv_out <= 1'b0;
      tick(HALF);
      scl_out <= 1'b0;
   endtask
   task automatic stop();
      sda_drv_out <= 1'b0;
      tick(HALF);
      scl_out <= 1'b1;
      tick(HALF);
      sda_drv_out <= 1'b1;
      tick(HALF);
   endtask
   // pointer write, data bytes, optional read after repeated start
   task automatic xfer(logic [6:0] a, logic [7:0] r, logic [7:0] d[$], int nrd);
      logic [7:0] x;
      logic ack;
      start();
      byte_io({a, 1'b0}, 1'b1, x, ack);
      report({7'h00, ack});
      if (ack) begin
         byte_io(r, 1'b1, x, ack);
         foreach (d[i]) byte_io(d[i], 1'b1, x, ack);
         if (nrd > 0) begin
            start();
            byte_io({a, 1'b1}, 1'b1, x, ack);
            report({7'h00, ack});
            for (int i = 0; i < nrd; i++) begin
               byte_io(8'hff, i == nrd - 1, x, ack);
               report(x);
            end
         end
      end
      stop();
   endtask
endmodule // ocr_host_model

/* tb/test_ocr_regs.sv */
// bench: control bank driven through the host model
module test_ocr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import ocr_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, pin_n = 1'b1, sw_rst = 1'b0; // clock and resets
   logic [31:0] rnd = 32'h57132943; // random source
   logic [6:0] img_addr = 7'h00; // image inputs
   logic [7:0] img_rev = 8'h00, img_ctl = 8'h01;
   logic [9:0] img_marg = 10'h000;
   logic commit = 1'b0, cal_done = 1'b0, pll_lock = 1'b0;
   logic scl, sda_drv, sda_oe, sda_o, ev_valid, pll_en, cal_rst, cal_start, lock_en, out_en;
   logic [7:0] ev_byte;
   logic [9:0] marg;
   logic [7:0] expq[$]; // expected bus events
   int miscompares = 0, compares = 0, starts = 0, cal_cnt = 0;
   always #5 clk_in = ~clk_in;
   ocr_host_model host (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl),
      .sda_drv_out(sda_drv), .ev_byte_out(ev_byte), .ev_valid_out(ev_valid));
   ocr_regs dut (.clk_in(clk_in), .rst_in(rst_in), .reset_pin_n_in(pin_n),
      .software_reset_bit_in(sw_rst), .scl_in(scl), .sda_in(sda_drv & ~sda_oe),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .nvm_target_address_in(img_addr),
      .nvm_image_revision_in(img_rev), .nvm_device_control_in(img_ctl),
      .nvm_margin_offset_in(img_marg), .nvm_commit_in(commit), .cal_done_in(cal_done),
      .pll_lock_in(pll_lock), .pll_enable_out(pll_en), .cal_reset_out(cal_rst),
      .cal_start_out(cal_start), .lock_enable_out(lock_en), .output_enable_out(out_en),
      .crystal_margin_offset_out(marg));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // calibration and lock stand-ins
   always @(posedge clk_in) begin
      cal_done <= (cal_cnt == 1);
      pll_lock <= lock_en;
      if (cal_start === 1'b1) begin
         cal_cnt <= 20;
         starts <= starts + 1;
      end else if (cal_cnt != 0) cal_cnt <= cal_cnt - 1;
   end
   // watcher: each bus event against the oldest note
   always @(posedge clk_in) begin
      if (ev_valid === 1'b1) begin
         if (expq.size() == 0) chk("unexpected bus event", 10'h3ff, 10'(ev_byte));
         else chk("bus event", 10'(expq.pop_front()), 10'(ev_byte));
      end
   end
   task automatic rd(logic [7:0] r, logic [7:0] e[$]);
      logic [7:0] none[$];
      expq = {expq, 8'h01, 8'h01, e};
      host.xfer(img_addr, r, none, e.size());
   endtask
   task automatic wr(logic [7:0] r, logic [7:0] d[$]);
      expq.push_back(8'h01);
      host.xfer(img_addr, r, d, 0);
   endtask
   // bounded wait for an output level
   task automatic wait_run(logic want);
      int n;
      n = 0;
      while (out_en !== want && n < 400) begin
         @(posedge clk_in);
         n++;
      end
      chk("output enable", 10'(want), 10'(out_en));
   endtask
   task automatic pulse_sw();
      @(posedge clk_in) sw_rst <= 1'b1;
      @(posedge clk_in) sw_rst <= 1'b0;
   endtask
   initial begin
      #800us;
      miscompares++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
   end
   initial begin
      logic [7:0] none[$];
      logic [9:0] v;
      int s0;
      rnd = lfsr(rnd);
      img_addr = {1'b0, rnd[5:0]}; // never the pre-image address
      img_rev = rnd[15:8];
      img_marg = rnd[25:16];
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      wait_run(1'b1);
      chk("pll enable", 10'h1, 10'(pll_en));
      chk("margin out", img_marg, marg);
      rd(OCR_ADDR_TARGET, '{{img_addr, 1'b0}, img_rev, 8'h01});
      rd(OCR_ADDR_MARG_HI, '{{6'h00, img_marg[1:0]}, img_marg[9:2]});
      rd(8'h20, '{8'h00});
      expq.push_back(8'h00);
      host.xfer(OCR_RST_TARGET, 8'h00, none, 0);
      wr(OCR_ADDR_TARGET, '{8'hff, 8'hff});
      rd(OCR_ADDR_TARGET, '{{img_addr, 1'b0}, img_rev});
      $display("test image and map done");
      rnd = lfsr(rnd);
      v = rnd[9:0];
      wr(OCR_ADDR_MARG_HI, '{{6'h3f, v[1:0]}, v[9:2]});
      rd(OCR_ADDR_MARG_HI, '{{6'h00, v[1:0]}, v[9:2]});
      chk("margin out", v, marg);
      $display("test margin done");
      wr(OCR_ADDR_CTL, '{8'h41});
      chk("pll enable", 10'h0, 10'(pll_en));
      chk("cal reset", 10'h1, 10'(cal_rst));
      s0 = starts;
      wr(OCR_ADDR_CTL, '{8'h01});
      wait_run(1'b1);
      chk("cal starts", 10'(s0 + 1), 10'(starts));
      s0 = starts;
      wr(OCR_ADDR_CTL, '{8'h03});
      wait_run(1'b1);
      chk("cal starts", 10'(s0 + 1), 10'(starts));
      rd(OCR_ADDR_CTL, '{8'h01});
      $display("test power down and trigger done");
      img_ctl <= 8'h00;
      pulse_sw();
      s0 = starts;
      rd(OCR_ADDR_CTL, '{8'h00});
      chk("cal starts", 10'(s0), 10'(starts));
      chk("output enable", 10'h0, 10'(out_en));
      chk("margin out", img_marg, marg);
      wr(OCR_ADDR_CTL, '{8'h02});
      wait_run(1'b1);
      chk("cal starts", 10'(s0 + 1), 10'(starts));
      img_ctl <= 8'h40;
      pin_n <= 1'b0;
      repeat (10) @(posedge clk_in);
      pin_n <= 1'b1;
      rd(OCR_ADDR_CTL, '{8'h40});
      chk("pll enable", 10'h0, 10'(pll_en));
      $display("test device resets done");
      v = {2'b00, ~img_rev};
      @(posedge clk_in) img_rev <= v[7:0];
      @(posedge clk_in) commit <= 1'b1;
      @(posedge clk_in) commit <= 1'b0;
      rd(OCR_ADDR_REV, '{v[7:0]});
      $display("test commit done");
      chk("pending events", 10'h0, 10'(expq.size()));
      give_verdict();
   end
endmodule // test_ocr_regs
